/* sdram_pkg.sv */
package sdram_pkg;

  // Pin group widths
  localparam int ADDR_W = 12;
  localparam int BA_W   = 2;
  localparam int DQ_W   = 8;
  localparam int NBANK  = 4;
  // Modelled page: columns per row, and row bits kept in storage
  localparam int COL_W  = 6;
  localparam int ROWK_W = 2;
  localparam int MEM_W  = BA_W + ROWK_W + COL_W;
  localparam int PIN_W  = 6 + BA_W + ADDR_W + DQ_W;

  // Mode register field layout
  localparam int BL_LSB   = 0;
  localparam int BL_W     = 3;
  localparam int BT_BIT   = 3;
  localparam int CL_LSB   = 4;
  localparam int CL_W     = 3;
  localparam int OPM_BIT  = 9;
  localparam int PREA_BIT = 10;
  localparam logic [BL_W-1:0] BL_ONE   = 3'h0;
  localparam logic [BL_W-1:0] BL_TWO   = 3'h1;
  localparam logic [BL_W-1:0] BL_FOUR  = 3'h2;
  localparam logic [BL_W-1:0] BL_EIGHT = 3'h3;
  localparam logic [BL_W-1:0] BL_FULL  = 3'h7;
  localparam logic [CL_W-1:0] CL_THREE = 3'h3;

  // Register bus
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_MODE   = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_REFCNT = 8'h0c;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Reset values
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h000;
  localparam logic              CTRL_RST = 1'h1;

endpackage : sdram_pkg

/* sdram_device.sv */
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module sdram_device (
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // Memory command pins
  input  wire logic                         cke,
  input  wire logic                         cs_n,
  input  wire logic                         ras_n,
  input  wire logic                         cas_n,
  input  wire logic                         we_n,
  input  wire logic                         dqm,
  input  wire logic [sdram_pkg::BA_W-1:0]   ba,
  input  wire logic [sdram_pkg::ADDR_W-1:0] addr,
  // Data pins
  input  wire logic [sdram_pkg::DQ_W-1:0]   dq_in,
  output wire logic [sdram_pkg::DQ_W-1:0]   dq_out,
  output wire logic                         dq_oe,
  // AXI4-Lite write channels
  input  wire logic                         awvalid,
  output wire logic                         awready,
  input  wire logic [sdram_pkg::AXI_AW-1:0] awaddr,
  input  wire logic                         wvalid,
  output wire logic                         wready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  output wire logic                         bvalid,
  input  wire logic                         bready,
  output wire logic [1:0]                   bresp,
  // AXI4-Lite read channels
  input  wire logic                         arvalid,
  output wire logic                         arready,
  input  wire logic [sdram_pkg::AXI_AW-1:0] araddr,
  output wire logic                         rvalid,
  input  wire logic                         rready,
  output wire logic [31:0]                  rdata,
  output wire logic [1:0]                   rresp
);
  import sdram_pkg::*;

  typedef struct packed {
    logic                            cke_prev;
    logic [ADDR_W-1:0]               mode;
    logic                            mode_valid;
    logic [NBANK-1:0]                open_mask;
    logic [NBANK-1:0][ADDR_W-1:0]    open_row;
    logic                            burst_on;
    logic                            burst_wr;
    logic [BA_W-1:0]                 burst_bank;
    logic [COL_W-1:0]                burst_start;
    logic [COL_W-1:0]                beat;
    logic                            susp;
    logic                            pd;
    logic [15:0]                     ref_cnt;
    logic [2:0]                      rd_v;
    logic [2:0][DQ_W-1:0]            rd_d;
    logic [1:0]                      dqm_d;
    logic                            full_en;
    logic                            aw_got;
    logic                            w_got;
    logic [AXI_AW-1:0]               aw_a;
    logic [31:0]                     w_d;
    logic [3:0]                      w_s;
    logic                            bv;
    logic [1:0]                      br;
    logic                            rv;
    logic [31:0]                     rd;
    logic [1:0]                      rr;
  } state_s;

  state_s                st;
  state_s                next_st;
  logic [DQ_W-1:0]       mem [0:(1<<MEM_W)-1];

  logic                  p_cke;
  logic                  p_cs_n;
  logic                  p_ras_n;
  logic                  p_cas_n;
  logic                  p_we_n;
  logic                  p_dqm;
  logic [BA_W-1:0]       p_ba;
  logic [ADDR_W-1:0]     p_addr;
  logic [DQ_W-1:0]       p_dq;
  logic                  ce;
  logic                  is_act;
  logic                  is_col;
  logic                  is_pre;
  logic                  is_mrs;
  logic                  is_ref;
  logic                  device_deselect;
  logic [BL_W-1:0]       bl_code;
  logic                  inter;
  logic                  cl3;
  logic                  full;
  logic                  cur_wr;
  logic [COL_W-1:0]      mask;
  logic [COL_W-1:0]      cur_start;
  logic [COL_W-1:0]      cur_beat;
  logic [COL_W-1:0]      cur_col;
  logic [BA_W-1:0]       cur_bank;
  logic                  pre_hit;
  logic                  active;
  logic                  last;
  logic [MEM_W-1:0]      mem_addr;
  logic                  mem_we;
  logic                  aw_hs;
  logic                  w_hs;
  logic                  ar_hs;

  // Pins used as they stand: the bus runs on this same clock, and a filter would swallow one-clock commands
  assign {p_cke, p_cs_n, p_ras_n, p_cas_n, p_we_n, p_dqm, p_ba, p_addr, p_dq} = {cke, cs_n, ras_n, cas_n, we_n, dqm,
                                                                                 ba, addr, dq_in};

  // Command decode; previous CKE gates every command
  assign ce              = st.cke_prev;
  assign device_deselect = p_cs_n;
  assign is_act = ce && !device_deselect && !p_ras_n && p_cas_n && p_we_n;
  assign is_col = ce && !device_deselect && p_ras_n && !p_cas_n;
  assign is_pre = ce && !device_deselect && !p_ras_n && p_cas_n && !p_we_n;
  assign is_mrs = ce && !device_deselect && !p_ras_n && !p_cas_n && !p_we_n;
  assign is_ref = ce && p_cke && !device_deselect && !p_ras_n && !p_cas_n && p_we_n;

  // Mode fields
  assign bl_code = st.mode[BL_LSB +: BL_W];
  assign inter   = st.mode[BT_BIT];
  assign cl3     = (st.mode[CL_LSB +: CL_W] == CL_THREE);
  // Full page needs the option enabled and the sequential order
  assign full    = (bl_code == BL_FULL) && !inter && st.full_en;

  // Burst operand: a new column command overrides the running burst
  assign cur_start = is_col ? p_addr[COL_W-1:0] : st.burst_start;
  assign cur_beat  = is_col ? '0 : st.beat;
  assign cur_wr    = is_col ? !p_we_n : st.burst_wr;
  assign cur_bank  = is_col ? p_ba : st.burst_bank;

  // Block mask from burst length; single-write mode writes one column, once per beat while a full page burst runs
  always_comb begin
    case (bl_code)
      BL_TWO:   mask = 6'h01;
      BL_FOUR:  mask = 6'h03;
      BL_EIGHT: mask = 6'h07;
      BL_FULL:  mask = full ? 6'h3f : 6'h00;
      default:  mask = 6'h00;
    endcase
    if (cur_wr && st.mode[OPM_BIT]) begin
      mask = 6'h00;
    end
  end

  // Column within the aligned block
  always_comb begin
    if (inter) begin
      cur_col = (cur_start & ~mask) | ((cur_start ^ cur_beat) & mask);
    end else begin
      cur_col = (cur_start & ~mask) | (COL_W'(cur_start + cur_beat) & mask);
    end
  end

  // Precharge of the burst bank ends the burst
  assign pre_hit  = is_pre && (p_addr[PREA_BIT] || p_ba == st.burst_bank);
  assign active   = is_col || (ce && st.burst_on && !pre_hit);
  // Full page never reaches a last beat by itself
  assign last     = !full && (cur_beat == mask);
  assign mem_addr = {cur_bank, st.open_row[cur_bank][ROWK_W-1:0], cur_col};
  // Zero-latency write mask
  assign mem_we   = active && cur_wr && !p_dqm;

  // Bus handshakes
  assign awready = !st.aw_got && !st.bv;
  assign wready  = !st.w_got && !st.bv;
  assign arready = !st.rv;
  assign aw_hs   = awvalid && awready;
  assign w_hs    = wvalid && wready;
  assign ar_hs   = arvalid && arready;

  // Next state
  always_comb begin
    next_st = st;
    next_st.cke_prev = p_cke;
    // Low CKE freezes the internal clock, so nothing in this block advances
    if (ce) begin
      if (is_mrs) begin
        next_st.mode       = p_addr;
        next_st.mode_valid = 1'b1;
      end
      if (is_act) begin
        next_st.open_mask[p_ba] = 1'b1;
        next_st.open_row[p_ba]  = p_addr;
      end
      if (is_pre) begin
        if (p_addr[PREA_BIT]) begin
          next_st.open_mask = '0;
        end else begin
          next_st.open_mask[p_ba] = 1'b0;
        end
      end
      if (is_ref) begin
        next_st.ref_cnt = st.ref_cnt + 16'h0001;
      end
      if (active) begin
        next_st.burst_on    = !last;
        next_st.beat        = COL_W'(cur_beat + 6'h01);
        next_st.burst_start = cur_start;
        next_st.burst_bank  = cur_bank;
        next_st.burst_wr    = cur_wr;
      end else if (pre_hit) begin
        next_st.burst_on = 1'b0;
      end
      // Read pipe; output stage picked by CAS latency
      next_st.rd_v  = {st.rd_v[1:0], active && !cur_wr};
      next_st.rd_d  = {st.rd_d[1:0], mem[mem_addr]};
      next_st.dqm_d = {st.dqm_d[0], p_dqm};
    end
    // CKE falling: busy bursts suspend instead of powering down
    if (p_cke) begin
      next_st.pd   = 1'b0;
      next_st.susp = 1'b0;
    end else if (ce) begin
      if (st.burst_on || (|st.rd_v)) begin
        next_st.susp = 1'b1;
      end else begin
        next_st.pd = 1'b1;
      end
    end
    // Write address and data may arrive in either order
    if (aw_hs) begin
      next_st.aw_got = 1'b1;
      next_st.aw_a   = awaddr;
    end
    if (w_hs) begin
      next_st.w_got = 1'b1;
      next_st.w_d   = wdata;
      next_st.w_s   = wstrb;
    end
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bv     = 1'b1;
      next_st.br     = RESP_SLVERR;
      case (st.aw_a & 8'hfc)
        OFS_CTRL: begin
          next_st.br = RESP_OKAY;
          if (st.w_s[0]) begin
            next_st.full_en = st.w_d[0];
          end
        end
        OFS_MODE, OFS_STATUS, OFS_REFCNT: next_st.br = RESP_OKAY;
        default: next_st.br = RESP_SLVERR;
      endcase
    end else if (st.bv && bready) begin
      next_st.bv = 1'b0;
    end
    // Reads answer one cycle after the address is taken
    if (ar_hs) begin
      next_st.rv = 1'b1;
      next_st.rr = RESP_OKAY;
      case (araddr & 8'hfc)
        OFS_CTRL:   next_st.rd = {31'h0, st.full_en};
        OFS_MODE:   next_st.rd = {19'h0, st.mode_valid, st.mode};
        OFS_STATUS: next_st.rd = {25'h0, st.pd, st.susp, st.burst_on, st.open_mask};
        OFS_REFCNT: next_st.rd = {16'h0, st.ref_cnt};
        default: begin
          next_st.rd = 32'h0;
          next_st.rr = RESP_SLVERR;
        end
      endcase
    end else if (st.rv && rready) begin
      next_st.rv = 1'b0;
    end
  end

  // State register; mode is cleared but flagged invalid until set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      next_st_reset();
    end else begin
      st <= next_st;
    end
  end

  task automatic next_st_reset();
    st          <= '0;
    st.mode     <= MODE_RST;
    st.full_en  <= CTRL_RST;
  endtask : next_st_reset

  // Storage array; kept outside the state record
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem[mem_addr] <= p_dq;
    end
  end

  // Read data drives after the latency; DQM cuts it two clocks on
  assign dq_out = cl3 ? st.rd_d[2] : st.rd_d[1];
  assign dq_oe  = (cl3 ? st.rd_v[2] : st.rd_v[1]) && !st.dqm_d[1];
  assign bvalid = st.bv;
  assign bresp  = st.br;
  assign rvalid = st.rv;
  assign rdata  = st.rd;
  assign rresp  = st.rr;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rd_cl2;
    (is_col && p_we_n && !cl3 && !p_dqm) ##1 ce;
  endsequence
  sequence s_dqm_hi;
    (ce && p_dqm) ##1 ce;
  endsequence

  a_mode_load: assert property (is_mrs |=> st.mode == $past(p_addr))
    else $error("mode not loaded from address");
  a_cke_gate: assert property (!ce && !p_cs_n && !p_ras_n && !p_cas_n && !p_we_n |=> $stable(st.mode))
    else $error("command taken with previous CKE low");
  a_row_open: assert property (is_act |=> st.open_mask[$past(p_ba)])
    else $error("activate did not open bank");
  a_pre_all: assert property (is_pre && p_addr[PREA_BIT] |=> st.open_mask == '0)
    else $error("precharge all left a bank open");
  a_read_lat: assert property (s_rd_cl2 |=> dq_oe)
    else $error("read data missing at latency two");
  a_dqm_off: assert property (s_dqm_hi |=> !dq_oe)
    else $error("output not disabled two clocks after mask");
  a_burst_end: assert property (ce && st.burst_on && !is_col && !pre_hit && last |=> !st.burst_on)
    else $error("burst ran past its length");
  a_full_wrap: assert property (ce && st.burst_on && full && !is_col && !pre_hit |=> st.burst_on)
    else $error("full page burst ended by itself");
  a_susp_hold: assert property (st.burst_on && !ce |=> $stable(st.beat))
    else $error("burst advanced during suspend");
  a_susp_enter: assert property (ce && !p_cke && st.burst_on |=> st.susp && !st.pd)
    else $error("power-down entered mid-burst");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");

endmodule : sdram_device

/* sdram_ctrl_model.sv */
`timescale 1ns/1ns
module sdram_ctrl_model #(
  parameter int PAUSE_CYC = 50000,
  parameter int RCD_CYC   = 2
) (
  // Clock
  input  wire logic        aclk,
  // Command pins
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic             dqm,
  output logic [1:0]       ba,
  output logic [11:0]      addr,
  // Write data
  output logic [7:0]       dq_in
);
  // Codes as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4;
  localparam logic [3:0] PRE = 4'h2, MRS = 4'h0, REF = 4'h1;

  // Power-up state: NOP, clock on, data masked
  initial begin
    {cs_n, ras_n, cas_n, we_n} = NOP;
    cke = 1'b1;
    dqm = 1'b1;
    ba = 2'h0;
    addr = 12'h000;
    dq_in = 8'h5a;
  end

  task automatic drive(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
    {cs_n, ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
  endtask : drive

  // One command, then a NOP cycle
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
    @(posedge aclk);
    drive(c, b, a);
    @(posedge aclk);
    drive(NOP, b, a);
  endtask : issue

  task automatic act(input logic [1:0] b, input logic [11:0] row);
    issue(ACT, b, row);
    repeat (RCD_CYC) @(posedge aclk);
  endtask : act

  task automatic col_rd(input logic [1:0] b, input logic [5:0] c);
    issue(RD, b, {6'h00, c});
  endtask : col_rd

  task automatic pre(input logic [1:0] b, input logic all);
    issue(PRE, b, {1'b0, all, 10'h000});
  endtask : pre

  // Banks closed first; the issue NOP follows the mode set
  task automatic set_mode(input logic [11:0] m);
    pre(2'h0, 1'b1);
    issue(MRS, 2'h0, m);
  endtask : set_mode

  // Pause, close all, refreshes, then mode before any activate
  task automatic init(input logic [11:0] m);
    repeat (PAUSE_CYC) @(posedge aclk);
    pre(2'h0, 1'b1);
    repeat (8) issue(REF, 2'h0, 12'h000);
    @(posedge aclk);
    dqm <= 1'b0;
    set_mode(m);
  endtask : init

  // Data rides with the command; a precharge ends the burst
  task automatic write(input logic [1:0] b, input logic [5:0] c, input int n, input logic [7:0] base,
                       input int mb);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      drive(i == 0 ? WR : NOP, b, {6'h00, c});
      dq_in <= base | {2'b00, c + 6'(i)};
      dqm <= (i == mb);
    end
    @(posedge aclk);
    drive(PRE, b, 12'h000);
    dq_in <= ~dq_in; // Released bus must not keep the last word
    dqm <= 1'b0;
    @(posedge aclk);
    drive(NOP, b, 12'h000);
  endtask : write

  task automatic set_cke(input logic v);
    @(posedge aclk);
    cke <= v;
  endtask : set_cke

  task automatic pulse_dqm;
    @(posedge aclk);
    dqm <= 1'b1;
    @(posedge aclk);
    dqm <= 1'b0;
  endtask : pulse_dqm

  // Write cutting a read: the mask silences the read drivers before the write word
  task automatic rd_then_wr(input logic [1:0] b, input logic [5:0] c, input logic [7:0] d);
    @(posedge aclk);
    drive(RD, b, {6'h00, c});
    dqm <= 1'b1;
    @(posedge aclk);
    drive(NOP, b, {6'h00, c});
    @(posedge aclk);
    drive(WR, b, {6'h00, c});
    dq_in <= d;
    dqm <= 1'b0;
    @(posedge aclk);
    drive(NOP, b, {6'h00, c});
    dqm <= 1'b1; // Rest of the write burst masked
    repeat (8) @(posedge aclk);
    dqm <= 1'b0;
  endtask : rd_then_wr
endmodule : sdram_ctrl_model

/* test_sdram_device.sv */
`timescale 1ns/1ns
module test_sdram_device;
  import sdram_pkg::*;
  // Bench-driven inputs
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  // Pins and outputs
  logic        awready, wready, bvalid, arready, rvalid, dq_oe, cke, cs_n, ras_n, cas_n, we_n, dqm;
  logic [1:0]  bresp, rresp, ba;
  logic [31:0] rdata;
  logic [7:0]  dq_out, dq_in;
  logic [11:0] addr;
  int          miscompares = 0, check_count = 0, lat2 = 0, lat3 = 0, lat = 0;

  sdram_ctrl_model #(.PAUSE_CYC(100)) ctl (.aclk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .dqm, .ba, .addr, .dq_in);
  sdram_device DUT (.aclk, .aresetn, .cke, .cs_n, .ras_n, .cas_n, .we_n, .dqm, .ba, .addr, .dq_in, .dq_out,
    .dq_oe, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);

  // Free-running clock
  always #2 aclk = ~aclk;

  // Stored word: bank 1 and bank 0, with the masked rewrite of 8..11
  function automatic logic [7:0] pat(input logic [1:0] b, input logic [5:0] c);
    if (b == 2'h1) return 8'hc0 | {2'b00, c};
    if (c == 6'h08 || c == 6'h0a || c == 6'h0b) return 8'h40 | {2'b00, c};
    return 8'h80 | {2'b00, c};
  endfunction : pat

  // Burst column, wrapping inside the aligned block
  function automatic logic [5:0] bcol(input logic [5:0] s, input int beat, input int len, input int il);
    logic [5:0] m;
    m = 6'(len - 1);
    return il != 0 ? (s & ~m) | ((s ^ 6'(beat)) & m) : (s & ~m) | ((s + 6'(beat)) & m);
  endfunction : bcol

  function automatic logic [11:0] mv(input logic [2:0] bl, input logic il, input logic [2:0] cl);
    return (12'(bl) << BL_LSB) | (12'(il) << BT_BIT) | (12'(cl) << CL_LSB);
  endfunction : mv

  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: register got %h exp %h", $time, g, e);
    end
  endtask : cmp32

  task automatic cmp_word(input logic oe, input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (oe !== 1'b1 || g !== e) begin
      miscompares++;
      $display("wrong value at %0t: read word got %h oe %b exp %h", $time, g, oe, e);
    end
  endtask : cmp_word

  task automatic close_out;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  // Address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit pa, pw, ta, tw;
    int k;
    pa = 1;
    pw = 1;
    k = 0;
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata <= d;
    while ((pa || pw) && k < 50) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
      k++;
    end
    k = 0;
    @(negedge aclk);
    while (bvalid !== 1'b1 && k < 50) begin
      @(negedge aclk);
      k++;
    end
    cmp32({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge aclk);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    @(negedge aclk);
    while (arready !== 1'b1 && k < 50) begin
      @(negedge aclk);
      k++;
    end
    @(posedge aclk);
    arvalid <= 1'b0;
    @(negedge aclk);
    while (rvalid !== 1'b1 && k < 100) begin
      @(negedge aclk);
      k++;
    end
    cmp32(rdata, ed);
    cmp32({29'h0, rvalid, rresp}, {29'h0, 1'b1, er});
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axi_rd

  // Optional interrupted bank-0 burst, then the checked burst
  task automatic rd(input logic [1:0] b, input logic [5:0] c, input int len, input int il, input int n,
                    input int pre, output int lt);
    int j;
    if (pre > 0) begin
      ctl.col_rd(2'h0, 6'h00);
      // The cut burst's first word shows while the new column goes out
      fork
        ctl.col_rd(b, c);
        begin
          repeat (2) @(negedge aclk);
          cmp_word(dq_oe, dq_out, pat(2'h0, 6'h00));
        end
      join
    end else begin
      ctl.col_rd(b, c);
    end
    j = 1;
    @(negedge aclk);
    while (dq_oe !== 1'b1 && j < 40) begin
      @(negedge aclk);
      j++;
    end
    lt = j;
    for (int i = (pre > 0) ? 1 : 0; i < pre + n; i++) begin
      if (i < pre) cmp_word(dq_oe, dq_out, pat(2'h0, bcol(6'h00, i, len, 0)));
      else cmp_word(dq_oe, dq_out, pat(b, bcol(c, i - pre, len, il)));
      @(negedge aclk);
    end
    if (n == len) cmp32({31'h0, dq_oe}, 32'h0);
  endtask : rd

  task automatic newmode(input logic [2:0] bl, input logic il, input logic [2:0] cl);
    ctl.set_mode(mv(bl, il, cl));
    ctl.act(2'h0, 12'h001);
    ctl.act(2'h1, 12'h002);
  endtask : newmode

  task automatic t_regs;
    axi_rd(OFS_CTRL, 32'(CTRL_RST), RESP_OKAY);
    axi_rd(OFS_MODE, 32'(MODE_RST), RESP_OKAY);
    axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
    axi_rd(OFS_CTRL, 32'h0, RESP_OKAY);
    axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
    axi_wr(OFS_MODE, 32'hfff, RESP_OKAY);
    axi_rd(OFS_MODE, 32'h0, RESP_OKAY);
    axi_wr(8'h10, 32'h0, RESP_SLVERR);
    axi_rd(8'h10, 32'h0, RESP_SLVERR);
  endtask : t_regs

  task automatic t_init_fill;
    ctl.init(mv(BL_FULL, 1'b0, 3'h2));
    axi_rd(OFS_REFCNT, 32'h8, RESP_OKAY);
    axi_rd(OFS_MODE, 32'h1000 | 32'(mv(BL_FULL, 1'b0, 3'h2)), RESP_OKAY);
    ctl.act(2'h0, 12'h001);
    ctl.act(2'h1, 12'h002);
    repeat (8) @(posedge aclk);
    axi_rd(OFS_STATUS, 32'h3, RESP_OKAY);
    ctl.write(2'h0, 6'h00, 64, 8'h80, 99);
    ctl.act(2'h0, 12'h001);
    ctl.write(2'h1, 6'h00, 64, 8'hc0, 99);
    ctl.act(2'h1, 12'h002);
    ctl.write(2'h0, 6'h08, 4, 8'h40, 1);
    ctl.act(2'h0, 12'h001);
  endtask : t_init_fill

  task automatic t_fullpage;
    rd(2'h0, 6'h3e, 64, 0, 70, 0, lat);
    ctl.pre(2'h0, 1'b0);
    newmode(BL_FULL, 1'b1, 3'h2);
    rd(2'h0, 6'h05, 1, 0, 1, 0, lat);
    axi_rd(OFS_MODE, 32'h1000 | 32'(mv(BL_FULL, 1'b1, 3'h2)), RESP_OKAY);
  endtask : t_fullpage

  task automatic t_modes;
    logic [2:0] codes [4];
    codes = '{BL_ONE, BL_TWO, BL_FOUR, BL_EIGHT};
    for (int k = 0; k < 8; k++) begin
      newmode(codes[k / 2], 1'(k % 2), 3'h2);
      rd(2'h1, 6'h0d, 1 << (k / 2), k % 2, 1 << (k / 2), 0, lat2);
    end
  endtask : t_modes

  task automatic t_latency_interrupt;
    newmode(BL_EIGHT, 1'b0, CL_THREE);
    rd(2'h0, 6'h00, 8, 0, 8, 0, lat3);
    cmp32(32'(lat3 - lat2), 32'h1);
    newmode(BL_EIGHT, 1'b0, 3'h2);
    rd(2'h1, 6'h04, 8, 0, 8, 2, lat);
  endtask : t_latency_interrupt

  // One mask cycle removes exactly one read word, two cycles later
  task automatic t_dqm;
    ctl.col_rd(2'h0, 6'h00);
    fork
      ctl.pulse_dqm();
      for (int j = 1; j < 32; j++) begin
        @(negedge aclk);
        cmp32({31'h0, dq_oe}, 32'(j >= lat2 && j < lat2 + 8 && j != lat2 + 2));
      end
    join
    // A masked read cut by a write never drives the bus
    fork
      ctl.rd_then_wr(2'h0, 6'h01, 8'h81);
      repeat (8) begin
        @(negedge aclk);
        cmp32({31'h0, dq_oe}, 32'h0);
      end
    join
  endtask : t_dqm

  task automatic t_power;
    ctl.pre(2'h1, 1'b0);
    repeat (8) @(posedge aclk);
    axi_rd(OFS_STATUS, 32'h1, RESP_OKAY);
    ctl.set_cke(1'b0);
    ctl.act(2'h2, 12'h003);
    repeat (8) @(posedge aclk);
    axi_rd(OFS_STATUS, 32'h41, RESP_OKAY);
    ctl.set_cke(1'b1);
    ctl.pre(2'h0, 1'b1);
    repeat (8) @(posedge aclk);
    axi_rd(OFS_STATUS, 32'h0, RESP_OKAY);
    newmode(BL_FULL, 1'b0, 3'h2);
    ctl.col_rd(2'h0, 6'h00);
    ctl.set_cke(1'b0);
    repeat (8) @(posedge aclk);
    axi_rd(OFS_STATUS, 32'h33, RESP_OKAY);
    ctl.set_cke(1'b1);
    ctl.pre(2'h0, 1'b1);
  endtask : t_power

  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_init_fill();
    t_fullpage();
    t_modes();
    t_latency_interrupt();
    t_dqm();
    t_power();
    close_out();
  end

  // Watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    close_out();
  end
endmodule : test_sdram_device
